/* File: dus_channel.sv */
`timescale 1ns/1ps
module dus_channel (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // register writes
   input wire logic wr_low,
   input wire logic wr_high,
   input wire logic wr_control,
   input wire logic [7:0] wdata,
   // timer overflow pulses, one cycle each
   input wire logic [2:0] timer_pulse,
   // register contents and input latch
   output dus_pkg::dus_chan_view_type view
);

   logic [7:0] data_low;
   logic [7:0] data_high;
   logic [7:0] control;
   logic [11:0] code;
   logic [7:0] next_low;
   logic [7:0] next_high;
   logic [11:0] next_code;
   logic update;
   dus_pkg::dus_mode_type mode;

   // ----------------------------------------------------------------
   // held data and control
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         data_low <= dus_pkg::RESET_BYTE;
         data_high <= dus_pkg::RESET_BYTE;
      end else begin
         data_low <= next_low;
         data_high <= next_high;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         control <= dus_pkg::RESET_BYTE;
      end else if (wr_control) begin
         control <= wdata & dus_pkg::CTRL_WRITE_MASK;
      end
   end

   assign next_low = wr_low ? wdata : data_low;
   assign next_high = wr_high ? wdata : data_high;
   assign mode = dus_pkg::dus_mode_type'(control[dus_pkg::CTRL_MODE_MSB:dus_pkg::CTRL_MODE_LSB]);

   // ----------------------------------------------------------------
   // update event selection
   // ----------------------------------------------------------------
   always_comb begin
      update = 1'b0;
      unique case (mode)
         dus_pkg::MODE_ON_WRITE: begin
            update = wr_high;
         end
         dus_pkg::MODE_TIMER3: begin
            update = timer_pulse[dus_pkg::TMR3_IDX];
         end
         dus_pkg::MODE_TIMER4: begin
            update = timer_pulse[dus_pkg::TMR4_IDX];
         end
         dus_pkg::MODE_TIMER2: begin
            update = timer_pulse[dus_pkg::TMR2_IDX];
         end
      endcase
   end

   dus_format u_format (
      .data_high(next_high),
      .data_low(next_low),
      .data_format(control[dus_pkg::CTRL_FMT_MSB:dus_pkg::CTRL_FMT_LSB]),
      .word(next_code)
   );

   // ----------------------------------------------------------------
   // converter input latch
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         code <= dus_pkg::RESET_WORD;
      end else if (update) begin
         code <= next_code;
      end
   end

   assign view = '{data_low: data_low, data_high: data_high, control: control, code: code};

endmodule

/* File: dus_chk.sv */
`timescale 1ns/1ps
module dus_chk (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // register access
   input wire logic [7:0] sfr_addr,
   input wire logic [7:0] sfr_page,
   input wire logic sfr_write,
   input wire logic sfr_read,
   input wire logic [7:0] sfr_wdata,
   input wire logic [7:0] sfr_rdata,
   input wire logic sfr_rdata_valid,
   // timers
   input wire logic timer2_overflow,
   input wire logic timer3_overflow,
   input wire logic timer4_overflow,
   // converters
   input wire logic [11:0] conv_a_code,
   input wire logic conv_a_output_enable,
   input wire logic conv_a_shutdown,
   input wire logic [11:0] conv_b_code,
   input wire logic conv_b_output_enable,
   input wire logic conv_b_shutdown
);
   // -------------
   // helpers
   // -------------
   logic tmr_any;
   assign tmr_any = timer2_overflow | timer3_overflow | timer4_overflow;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   sequence s_ctrl_a;
      sfr_write && sfr_addr == 8'hd4 && sfr_page == 8'h00;
   endsequence
   sequence s_ctrl_b;
      sfr_write && sfr_addr == 8'hd4 && sfr_page == 8'h01;
   endsequence
   // -------------
   // assertions
   // -------------
   a_read_valid: assert property (
      sfr_read |=> sfr_rdata_valid)
      else $error("read gave no valid");
   a_idle_rdata_zero: assert property (
      !sfr_read |=> !sfr_rdata_valid && sfr_rdata == 8'h00)
      else $error("read data without read");
   a_ctrl_unused_zero: assert property (
      sfr_read && sfr_addr == 8'hd4 |=> sfr_rdata[6:5] == 2'h0)
      else $error("unused control bits set");
   a_page_unmapped: assert property (
      sfr_read && sfr_page > 8'h01 |=> sfr_rdata == 8'h00)
      else $error("unmapped page read nonzero");
   a_enable_a: assert property (
      s_ctrl_a |-> ##2 conv_a_output_enable == $past(sfr_wdata[7], 2))
      else $error("enable a wrong");
   a_enable_b: assert property (
      s_ctrl_b |-> ##2 conv_b_output_enable == $past(sfr_wdata[7], 2))
      else $error("enable b wrong");
   a_shutdown_inv: assert property (
      conv_a_shutdown != conv_a_output_enable &&
      conv_b_shutdown != conv_b_output_enable)
      else $error("shutdown not inverse");
   a_code_cause: assert property (
      $changed(conv_a_code) || $changed(conv_b_code) |->
         $past(sfr_write) || $past(tmr_any, 2))
      else $error("code moved without cause");
   a_reset_clear: assert property (
      disable iff (1'b0) $fell(rst) |->
         conv_a_code == 12'h000 && conv_b_code == 12'h000 &&
         conv_a_shutdown && conv_b_shutdown)
      else $error("reset did not clear");
endmodule

bind dus_top dus_chk chk_u (.*);

/* File: dus_format.sv */
`timescale 1ns/1ps
module dus_format (
   // held data bytes and format select
   input wire logic [7:0] data_high,
   input wire logic [7:0] data_low,
   input wire logic [2:0] data_format,
   // assembled converter word
   output logic [11:0] word
);

   always_comb begin
      word = dus_pkg::RESET_WORD;
      casez (data_format)
         dus_pkg::FMT_HIGH_NIBBLE: begin
            word = {data_high[3:0], data_low};
         end
         dus_pkg::FMT_HIGH_FIVE: begin
            word = {data_high[4:0], data_low[7:1]};
         end
         dus_pkg::FMT_HIGH_SIX: begin
            word = {data_high[5:0], data_low[7:2]};
         end
         dus_pkg::FMT_HIGH_SEVEN: begin
            word = {data_high[6:0], data_low[7:3]};
         end
         default: begin
            // top format bit set
            word = {data_high, data_low[7:4]};
         end
      endcase
   end

endmodule

/* File: dus_pkg.sv */
package dus_pkg;

   // ----------------------------------------------------------------
   // widths
   // ----------------------------------------------------------------
   localparam int unsigned BYTE_WIDTH = 8;
   localparam int unsigned WORD_WIDTH = 12;
   localparam int unsigned CHAN_COUNT = 2;
   localparam int unsigned TIMER_COUNT = 3;

   // ----------------------------------------------------------------
   // register map: address within the special-register space, page
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_DATA_LOW = 8'hd2;
   localparam logic [7:0] ADDR_DATA_HIGH = 8'hd3;
   localparam logic [7:0] ADDR_CONTROL = 8'hd4;
   localparam logic [7:0] PAGE_CONV_A = 8'h00;
   localparam logic [7:0] PAGE_CONV_B = 8'h01;

   // ----------------------------------------------------------------
   // control register fields
   // ----------------------------------------------------------------
   localparam int unsigned CTRL_ENABLE_BIT = 7;
   localparam int unsigned CTRL_MODE_MSB = 4;
   localparam int unsigned CTRL_MODE_LSB = 3;
   localparam int unsigned CTRL_FMT_MSB = 2;
   localparam int unsigned CTRL_FMT_LSB = 0;
   localparam logic [7:0] CTRL_WRITE_MASK = 8'h9f;

   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam logic [11:0] RESET_WORD = 12'h000;

   // ----------------------------------------------------------------
   // update modes and data formats
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      MODE_ON_WRITE = 2'h0,
      MODE_TIMER3 = 2'h1,
      MODE_TIMER4 = 2'h2,
      MODE_TIMER2 = 2'h3
   } dus_mode_type;

   localparam logic [2:0] FMT_HIGH_NIBBLE = 3'h0;
   localparam logic [2:0] FMT_HIGH_FIVE = 3'h1;
   localparam logic [2:0] FMT_HIGH_SIX = 3'h2;
   localparam logic [2:0] FMT_HIGH_SEVEN = 3'h3;

   // timer pulse vector positions
   localparam int unsigned TMR2_IDX = 0;
   localparam int unsigned TMR3_IDX = 1;
   localparam int unsigned TMR4_IDX = 2;

   // ----------------------------------------------------------------
   // carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] page;
      logic write;
      logic read;
      logic [7:0] wdata;
   } dus_sfr_req_type;

   typedef struct packed {
      logic [7:0] data_low;
      logic [7:0] data_high;
      logic [7:0] control;
      logic [11:0] code;
   } dus_chan_view_type;

endpackage

/* File: dus_top.sv */
// Summary of operation
// - mode 00 latches word on high write
// - low write alone only held in mode 00
// - modes 01/10/11 pick timer 3/4/2
// - timer modes hold writes, copy on overflow
// - format 000: high[3:0] and whole low
// - format 001: high[4:0] and low[7:1]
// - format 010: high[5:0] and low[7:2]
// - format 011: high[6:0] and low[7:3]
// - format 1xx: whole high and low[7:4]
// - enable bit drives pin, else shutdown
// - control bits 6:5 read zero, ignore writes
// - second converter identical, own registers
// - second converter selected on page one
// - readable writable low and high bytes
`timescale 1ns/1ps
module dus_top (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // special-register access
   input wire logic [7:0] sfr_addr,
   input wire logic [7:0] sfr_page,
   input wire logic sfr_write,
   input wire logic sfr_read,
   input wire logic [7:0] sfr_wdata,
   output logic [7:0] sfr_rdata,
   output logic sfr_rdata_valid,
   // timer overflow strobes from on-chip timers
   input wire logic timer2_overflow,
   input wire logic timer3_overflow,
   input wire logic timer4_overflow,
   // converter a
   output logic [11:0] conv_a_code,
   output logic conv_a_output_enable,
   output logic conv_a_shutdown,
   // converter b
   output logic [11:0] conv_b_code,
   output logic conv_b_output_enable,
   output logic conv_b_shutdown
);

   localparam logic [7:0] CHAN_PAGE [dus_pkg::CHAN_COUNT] = '{
      dus_pkg::PAGE_CONV_A,
      dus_pkg::PAGE_CONV_B
   };

   dus_pkg::dus_sfr_req_type req;
   logic [2:0] timer_raw;
   logic [2:0] timer_prev;
   logic [2:0] timer_pulse;
   logic [dus_pkg::CHAN_COUNT-1:0] page_hit;
   logic [dus_pkg::CHAN_COUNT-1:0] wr_low;
   logic [dus_pkg::CHAN_COUNT-1:0] wr_high;
   logic [dus_pkg::CHAN_COUNT-1:0] wr_control;
   dus_pkg::dus_chan_view_type view [dus_pkg::CHAN_COUNT];
   logic [7:0] next_rdata;

   // ----------------------------------------------------------------
   // elaboration checks
   // ----------------------------------------------------------------
   if (dus_pkg::TIMER_COUNT != $bits(timer_raw) ||
       dus_pkg::CHAN_COUNT != $bits({conv_a_shutdown, conv_b_shutdown})) begin : g_bad_size
      $error("package counts do not match the timer and converter ports");
   end

   assign req = '{addr: sfr_addr, page: sfr_page, write: sfr_write,
                  read: sfr_read, wdata: sfr_wdata};

   // ----------------------------------------------------------------
   // timer overflow edge detection
   // ----------------------------------------------------------------
   assign timer_raw[dus_pkg::TMR2_IDX] = timer2_overflow;
   assign timer_raw[dus_pkg::TMR3_IDX] = timer3_overflow;
   assign timer_raw[dus_pkg::TMR4_IDX] = timer4_overflow;

   genvar t;
   generate
      for (t = 0; t < dus_pkg::TIMER_COUNT; t++) begin : g_timer
         always_ff @(posedge clk) begin
            if (rst) begin
               timer_prev[t] <= 1'b0;
               timer_pulse[t] <= 1'b0;
            end else begin
               timer_prev[t] <= timer_raw[t];
               // one pulse per rising edge of the strobe
               timer_pulse[t] <= timer_raw[t] & ~timer_prev[t];
            end
         end
      end
   endgenerate

   // ----------------------------------------------------------------
   // converter channels
   // ----------------------------------------------------------------
   genvar c;
   generate
      for (c = 0; c < dus_pkg::CHAN_COUNT; c++) begin : g_chan
         assign page_hit[c] = (req.page == CHAN_PAGE[c]);
         assign wr_low[c] = req.write & page_hit[c] & (req.addr == dus_pkg::ADDR_DATA_LOW);
         assign wr_high[c] = req.write & page_hit[c] & (req.addr == dus_pkg::ADDR_DATA_HIGH);
         assign wr_control[c] = req.write & page_hit[c] & (req.addr == dus_pkg::ADDR_CONTROL);

         // identical logic per converter
         dus_channel u_chan (
            .clk(clk),
            .rst(rst),
            .wr_low(wr_low[c]),
            .wr_high(wr_high[c]),
            .wr_control(wr_control[c]),
            .wdata(req.wdata),
            .timer_pulse(timer_pulse),
            .view(view[c])
         );
      end
   endgenerate

   // ----------------------------------------------------------------
   // read data
   // ----------------------------------------------------------------
   always_comb begin
      next_rdata = dus_pkg::RESET_BYTE;
      for (int i = 0; i < dus_pkg::CHAN_COUNT; i++) begin
         if (page_hit[i]) begin
            if (req.addr == dus_pkg::ADDR_DATA_LOW) begin
               next_rdata = view[i].data_low;
            end else if (req.addr == dus_pkg::ADDR_DATA_HIGH) begin
               next_rdata = view[i].data_high;
            end else if (req.addr == dus_pkg::ADDR_CONTROL) begin
               next_rdata = view[i].control;
            end
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         sfr_rdata <= dus_pkg::RESET_BYTE;
         sfr_rdata_valid <= 1'b0;
      end else begin
         sfr_rdata <= req.read ? next_rdata : dus_pkg::RESET_BYTE;
         sfr_rdata_valid <= req.read;
      end
   end

   // ----------------------------------------------------------------
   // converter outputs
   // ----------------------------------------------------------------
   assign conv_a_code = view[0].code;
   assign conv_b_code = view[1].code;

   always_ff @(posedge clk) begin
      if (rst) begin
         conv_a_output_enable <= 1'b0;
         conv_a_shutdown <= 1'b1;
         conv_b_output_enable <= 1'b0;
         conv_b_shutdown <= 1'b1;
      end else begin
         conv_a_output_enable <= view[0].control[dus_pkg::CTRL_ENABLE_BIT];
         conv_a_shutdown <= ~view[0].control[dus_pkg::CTRL_ENABLE_BIT];
         conv_b_output_enable <= view[1].control[dus_pkg::CTRL_ENABLE_BIT];
         conv_b_shutdown <= ~view[1].control[dus_pkg::CTRL_ENABLE_BIT];
      end
   end

endmodule

/* File: tb.sv */
`timescale 1ns/1ps
module tb;
   // -------------
   // signals
   // -------------
   logic clk, rst, sfr_write, sfr_read, sfr_rdata_valid, oe_a, oe_b, sd_a, sd_b;
   logic [7:0] sfr_addr, sfr_page, sfr_wdata, sfr_rdata;
   logic [2:0] tmr;
   logic [11:0] code_a, code_b, exp_a, exp_b;
   int fail_count, check_count, cyc;

   dus_top dut_u (
      .clk(clk), .rst(rst), .sfr_addr(sfr_addr), .sfr_page(sfr_page),
      .sfr_write(sfr_write), .sfr_read(sfr_read), .sfr_wdata(sfr_wdata),
      .sfr_rdata(sfr_rdata), .sfr_rdata_valid(sfr_rdata_valid),
      .timer2_overflow(tmr[0]), .timer3_overflow(tmr[1]), .timer4_overflow(tmr[2]),
      .conv_a_code(code_a), .conv_a_output_enable(oe_a), .conv_a_shutdown(sd_a),
      .conv_b_code(code_b), .conv_b_output_enable(oe_b), .conv_b_shutdown(sd_b)
   );

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   function automatic logic [11:0] fmt(input logic [2:0] f, input logic [7:0] h, l);
      case (f)
         3'h0: return {h[3:0], l};
         3'h1: return {h[4:0], l[7:1]};
         3'h2: return {h[5:0], l[7:2]};
         3'h3: return {h[6:0], l[7:3]};
         default: return {h, l[7:4]};
      endcase
   endfunction

   task automatic chk(input logic [11:0] got, input logic [11:0] exp);
      check_count++;
      if (got !== exp) begin
         fail_count++;
         $display("Error t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] p, input logic [7:0] a, input logic [7:0] d);
      sfr_page <= p;
      sfr_addr <= a;
      sfr_wdata <= d;
      sfr_write <= 1'b1;
      @(posedge clk);
      sfr_write <= 1'b0;
      @(posedge clk);
   endtask

   task automatic rd(input logic [7:0] p, input logic [7:0] a, input logic [7:0] e);
      sfr_page <= p;
      sfr_addr <= a;
      sfr_read <= 1'b1;
      @(posedge clk);
      sfr_read <= 1'b0;
      #1;
      chk({3'h0, sfr_rdata_valid, sfr_rdata}, {4'h1, e});
      @(posedge clk);
   endtask

   // one-cycle strobe, code lands two edges later
   task automatic pulse(input int i);
      tmr[i] <= 1'b1;
      @(posedge clk);
      tmr <= 3'h0;
      repeat (2) @(posedge clk);
   endtask

   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         fail_count++;
         report_and_stop();
      end
   end

   initial begin
      rst = 1'b1;
      sfr_addr = 8'h00;
      sfr_page = 8'h00;
      sfr_wdata = 8'h00;
      sfr_write = 1'b0;
      sfr_read = 1'b0;
      tmr = 3'h0;
      fail_count = 0;
      check_count = 0;
      cyc = 0;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      for (int r = 0; r < 6; r++) begin
         rd(8'(r / 3), 8'(8'hd2 + r % 3), 8'h00);
      end
      chk({8'h00, oe_a, sd_a, oe_b, sd_b}, 12'h005);
      chk(code_a | code_b, 12'h000);
      wr(8'h00, 8'hd4, 8'hff);
      rd(8'h00, 8'hd4, 8'h9f);
      rd(8'h01, 8'hd4, 8'h00);
      rd(8'h02, 8'hd4, 8'h00);
      chk({10'h0, oe_a, sd_a}, 12'h002);
      exp_a = 12'h000;
      for (int f = 0; f < 8; f++) begin
         wr(8'h00, 8'hd4, {5'h10, 3'(f)});
         wr(8'h01, 8'hd4, {5'h00, 3'(7 - f)});
         wr(8'h00, 8'hd2, 8'h6b ^ 8'(f));
         wr(8'h01, 8'hd2, 8'hd4);
         chk(code_a, exp_a);
         wr(8'h00, 8'hd3, 8'hc9);
         wr(8'h01, 8'hd3, 8'h3e ^ 8'(f));
         exp_a = fmt(3'(f), 8'hc9, 8'h6b ^ 8'(f));
         exp_b = fmt(3'(7 - f), 8'h3e ^ 8'(f), 8'hd4);
         chk(code_a, exp_a);
         chk(code_b, exp_b);
      end
      rd(8'h01, 8'hd3, 8'h39);
      chk({10'h0, oe_b, sd_b}, 12'h001);
      for (int m = 1; m < 4; m++) begin
         wr(8'h00, 8'hd4, {3'h4, 2'(m), 3'h0});
         wr(8'h00, 8'hd2, 8'(m * 16 + 5));
         wr(8'h00, 8'hd3, 8'(m + 8));
         chk(code_a, exp_a);
         for (int i = 0; i < 3; i++) begin
            if (i != m % 3) begin
               pulse(i);
               chk(code_a, exp_a);
            end
         end
         pulse(m % 3);
         exp_a = fmt(3'h0, 8'(m + 8), 8'(m * 16 + 5));
         chk(code_a, exp_a);
      end
      // held-high strobe counts once
      wr(8'h00, 8'hd2, 8'h77);
      chk(code_a, exp_a);
      tmr[0] <= 1'b1;
      repeat (3) @(posedge clk);
      exp_a = fmt(3'h0, 8'h0b, 8'h77);
      chk(code_a, exp_a);
      wr(8'h00, 8'hd2, 8'h88);
      chk(code_a, exp_a);
      tmr <= 3'h0;
      report_and_stop();
   end
endmodule
